// [common/vsp_params.svh]
`ifndef VSP_PARAMS_SVH
`define VSP_PARAMS_SVH

// clock and serial line
`define VSP_CLK_HZ 10000000
`define VSP_BAUD 115200
// notification lead and tail time, microseconds
`define VSP_GUARD_US 100
// unit step between hz, khz and microseconds
`define VSP_KILO 1000
// message buffer
`define VSP_FIFO_DEPTH 16
`define VSP_DATA_W 8
// frame layout: start, 8 data, stop
`define VSP_FRAME_LAST 4'h9
`define VSP_DATA_LAST 3'h7
`define VSP_IDLE_LEVEL 1'b1
`define VSP_START_LEVEL 1'b0

`endif

// [common/vsp_pkg.sv]
`include "vsp_params.svh"

package vsp_pkg;

  // one byte of an outgoing message
  typedef struct packed {
    logic chan_b;
    logic last;
    logic [`VSP_DATA_W-1:0] data;
  } vsp_beat_t;

  typedef enum logic [1:0] {TX_IDLE, TX_LEAD, TX_SEND, TX_TAIL} vsp_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} vsp_rx_state_t;

  typedef struct packed {
    vsp_tx_state_t tx_state;
    logic [11:0] guard;
    logic [7:0] tx_div;
    logic [3:0] tx_idx;
    logic [9:0] tx_sh;
    logic tx_busy;
    logic tx_last;
    logic txd;
    logic int_n;
    logic chan_a;
    logic chan_b;
    logic rx_s1;
    logic rx_s2;
    vsp_rx_state_t rx_state;
    logic [7:0] rx_div;
    logic [2:0] rx_idx;
    logic [7:0] rx_sh;
    logic [7:0] cmd_data;
    logic cmd_valid;
    logic cmd_err;
  } vsp_state_t;

endpackage

// [src/vsp_fifo.sv]
`timescale 1ns/100ps
`include "vsp_params.svh"

module vsp_fifo import vsp_pkg::*; #(
  parameter int WIDTH = 10,
  parameter int DEPTH = `VSP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic in_ready;
  } vsp_fifo_state_t;

  vsp_fifo_state_t q_reg, q_next;
  logic push, pop;

  assign push = in_valid_i && q_reg.in_ready;
  assign pop = out_ready_i && (q_reg.count != '0);
  assign in_ready_o = q_reg.in_ready;
  assign out_valid_o = (q_reg.count != '0);
  assign out_data_o = q_reg.mem[q_reg.rd_ptr];

  always_comb begin
    q_next = q_reg;
    if (push) begin
      q_next.mem[q_reg.wr_ptr] = in_data_i;
      q_next.wr_ptr = (q_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : q_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      q_next.rd_ptr = (q_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : q_reg.rd_ptr + 1'b1;
    end
    q_next.count = q_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
    q_next.in_ready = (q_next.count != (AW + 1)'(DEPTH));
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_reg <= '{mem: '0, wr_ptr: '0, rd_ptr: '0, count: '0, in_ready: 1'b1};
    end else begin
      q_reg <= q_next;
    end
  end

  full_refuses_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q_reg.count == (AW + 1)'(DEPTH)) |-> !in_ready_o)
    else $error("fifo full but ready");

endmodule // vsp_fifo

// [src/vsp_port.sv]
`timescale 1ns/100ps
`include "vsp_params.svh"

// Notes on behaviour
// - A low level on the reset input holds the port in reset; a high level lets it run normally.
// - The pending output goes low at least 100 us before the first byte and stays low meanwhile.
// - The pending output returns high after the message completes and stays high when idle.
// - Channel A activity rises with pending for a channel A message and drops after it.
// - Channel B activity rises with pending for a channel B message and drops after it.
// - Telecommands arrive as 115200 baud 8N1 frames on the receive line; a frame with a low stop bit raises cmd_err instead of cmd_valid.
// - Messages leave as 115200 baud 8N1 frames on the transmit line.
// - A 100 us guard separates the notifications from the first and last transmitted bits.
// - Activity outputs follow only checked messages and name the channel they came from.

module vsp_port import vsp_pkg::*; #(
  parameter int CLK_HZ = `VSP_CLK_HZ,
  parameter int BAUD = `VSP_BAUD,
  parameter int GUARD_US = `VSP_GUARD_US,
  parameter int DEPTH = `VSP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // checked message bytes from the decoder
  input wire logic [`VSP_DATA_W-1:0] msg_data_i,
  input wire logic msg_last_i,
  input wire logic msg_chan_b_i,
  input wire logic msg_valid_i,
  output logic msg_ready_o,
  // host pins
  input wire logic rxd_i,
  output logic txd_o,
  output logic int_n_o,
  output logic chan_a_o,
  output logic chan_b_o,
  // received telecommands
  output logic [`VSP_DATA_W-1:0] cmd_data_o,
  output logic cmd_valid_o,
  output logic cmd_err_o
);

  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int HALF_CYC = BIT_CYC / 2;
  localparam int GUARD_CYC = (GUARD_US * (CLK_HZ / `VSP_KILO) + `VSP_KILO - 1) / `VSP_KILO;

  ////////////////////////////////////////////////////////////////////////////
  // message buffer

  vsp_beat_t in_beat, f_beat;
  logic f_valid, f_pop, f_ready;

  assign in_beat = '{chan_b: msg_chan_b_i, last: msg_last_i, data: msg_data_i};

  vsp_fifo #(.WIDTH($bits(vsp_beat_t)), .DEPTH(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(in_beat),
    .in_valid_i(msg_valid_i),
    .in_ready_o(f_ready),
    .out_data_o(f_beat),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop)
  );

  assign msg_ready_o = f_ready;

  ////////////////////////////////////////////////////////////////////////////
  // state

  vsp_state_t q_reg, q_next;

  assign f_pop = (q_reg.tx_state == TX_SEND) && !q_reg.tx_busy && !q_reg.tx_last && f_valid;

  always_comb begin
    q_next = q_reg;
    q_next.cmd_valid = 1'b0;
    q_next.cmd_err = 1'b0;
    // transmit sequencer
    unique case (q_reg.tx_state)
      TX_IDLE: begin
        q_next.int_n = 1'b1;
        q_next.chan_a = 1'b0;
        q_next.chan_b = 1'b0;
        if (f_valid) begin
          q_next.int_n = 1'b0;
          q_next.chan_a = !f_beat.chan_b;
          q_next.chan_b = f_beat.chan_b;
          q_next.guard = '0;
          q_next.tx_last = 1'b0;
          q_next.tx_state = TX_LEAD;
        end
      end
      TX_LEAD: begin
        q_next.guard = q_reg.guard + 1'b1;
        if (q_reg.guard == 12'(GUARD_CYC - 1)) begin
          q_next.tx_state = TX_SEND;
        end
      end
      TX_SEND: begin
        if (q_reg.tx_busy) begin
          q_next.tx_div = q_reg.tx_div + 1'b1;
          if (q_reg.tx_div == 8'(BIT_CYC - 1)) begin
            q_next.tx_div = '0;
            q_next.tx_sh = {`VSP_IDLE_LEVEL, q_reg.tx_sh[9:1]};
            q_next.txd = q_reg.tx_sh[1];
            q_next.tx_idx = q_reg.tx_idx + 1'b1;
            if (q_reg.tx_idx == `VSP_FRAME_LAST) begin
              q_next.tx_busy = 1'b0;
              q_next.txd = `VSP_IDLE_LEVEL;
              if (q_reg.tx_last) begin
                q_next.guard = '0;
                q_next.tx_state = TX_TAIL;
              end
            end
          end
        end else if (f_pop) begin
          q_next.tx_sh = {`VSP_IDLE_LEVEL, f_beat.data, `VSP_START_LEVEL};
          q_next.txd = `VSP_START_LEVEL;
          q_next.tx_div = '0;
          q_next.tx_idx = '0;
          q_next.tx_busy = 1'b1;
          q_next.tx_last = f_beat.last;
        end
      end
      TX_TAIL: begin
        q_next.guard = q_reg.guard + 1'b1;
        if (q_reg.guard == 12'(GUARD_CYC - 1)) begin
          q_next.int_n = 1'b1;
          q_next.chan_a = 1'b0;
          q_next.chan_b = 1'b0;
          q_next.tx_state = TX_IDLE;
        end
      end
    endcase
    // receive line synchroniser
    q_next.rx_s1 = rxd_i;
    q_next.rx_s2 = q_reg.rx_s1;
    // telecommand receiver, sampling mid bit
    q_next.rx_div = (q_reg.rx_div == '0) ? '0 : q_reg.rx_div - 1'b1;
    unique case (q_reg.rx_state)
      RX_IDLE: begin
        if (q_reg.rx_s2 == `VSP_START_LEVEL) begin
          q_next.rx_div = 8'(HALF_CYC - 1);
          q_next.rx_state = RX_START;
        end
      end
      RX_START: begin
        if (q_reg.rx_div == '0) begin
          q_next.rx_div = 8'(BIT_CYC - 1);
          q_next.rx_idx = '0;
          q_next.rx_state = (q_reg.rx_s2 == `VSP_START_LEVEL) ? RX_DATA : RX_IDLE;
        end
      end
      RX_DATA: begin
        if (q_reg.rx_div == '0) begin
          q_next.rx_div = 8'(BIT_CYC - 1);
          q_next.rx_sh = {q_reg.rx_s2, q_reg.rx_sh[7:1]};
          q_next.rx_idx = q_reg.rx_idx + 1'b1;
          if (q_reg.rx_idx == `VSP_DATA_LAST) begin
            q_next.rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (q_reg.rx_div == '0) begin
          if (q_reg.rx_s2 == `VSP_IDLE_LEVEL) begin
            q_next.rx_state = RX_IDLE;
            if (q_reg.rx_idx == '0) begin
              q_next.cmd_data = q_reg.rx_sh;
              q_next.cmd_valid = 1'b1;
            end
          end else if (q_reg.rx_idx == '0) begin
            // broken stop: report once, then wait for an idle line
            q_next.cmd_err = 1'b1;
            q_next.rx_idx = 3'h1;
          end
        end
      end
    endcase
  end

  // async low reset holds everything idle; txd and pending released high, channel pins low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_reg <= '{tx_state: TX_IDLE, rx_state: RX_IDLE, txd: 1'b1, int_n: 1'b1,
                 rx_s1: 1'b1, rx_s2: 1'b1, default: '0};
    end else begin
      q_reg <= q_next;
    end
  end

  assign txd_o = q_reg.txd;
  assign int_n_o = q_reg.int_n;
  assign chan_a_o = q_reg.chan_a;
  assign chan_b_o = q_reg.chan_b;
  assign cmd_data_o = q_reg.cmd_data;
  assign cmd_valid_o = q_reg.cmd_valid;
  assign cmd_err_o = q_reg.cmd_err;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  localparam int GUARD_MIN = GUARD_CYC;
  logic [11:0] low_cnt, high_cnt;

  // cycles with pending low, cycles with line high
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt <= '0;
      high_cnt <= '0;
    end else begin
      low_cnt <= int_n_o ? '0 : ((&low_cnt) ? low_cnt : low_cnt + 1'b1);
      high_cnt <= !txd_o ? '0 : ((&high_cnt) ? high_cnt : high_cnt + 1'b1);
    end
  end

  sequence start_bit_s;
    $fell(txd_o);
  endsequence

  sequence release_s;
    $rose(int_n_o);
  endsequence

  lead_guard_a: assert property (start_bit_s |-> low_cnt >= 12'(GUARD_MIN))
    else $error("start bit too soon after pending");
  tail_guard_a: assert property (release_s |-> high_cnt >= 12'(GUARD_MIN))
    else $error("pending released too soon after last bit");
  idle_high_a: assert property ((q_reg.tx_state == TX_IDLE) |-> int_n_o && txd_o)
    else $error("pending or line low while idle");
  chan_a_pair_a: assert property (chan_a_o |-> !int_n_o)
    else $error("channel a active without pending");
  chan_b_pair_a: assert property (chan_b_o |-> !int_n_o)
    else $error("channel b active without pending");
  one_channel_a: assert property (!int_n_o |-> (chan_a_o ^ chan_b_o))
    else $error("channel outputs do not name one channel");
  start_width_a: assert property (start_bit_s |-> !txd_o [*8])
    else $error("start bit too short");
  cmd_pulse_a: assert property (cmd_valid_o |=> !cmd_valid_o && !cmd_err_o)
    else $error("telecommand strobe longer than one cycle");
  chan_hold_a: assert property (!int_n_o && !$past(int_n_o) |-> $stable(chan_b_o))
    else $error("channel changed during message");

endmodule // vsp_port

// [tb/vsp_host.sv]
`timescale 1ns/100ps

module vsp_host #(
  parameter int BIT = 86
) (
  // clock
  input wire logic clk_i,
  // device pins
  input wire logic txd_i,
  input wire logic int_n_i,
  input wire logic chan_a_i,
  input wire logic chan_b_i,
  output logic rxd_o
);
  logic [10:0] got_q[$];
  int lead_q[$];
  int tail_q[$];
  int lead = 0;
  int hi = 0;
  logic int_prev = 1'b1;
  logic tag_a = 1'b0;
  logic tag_b = 1'b0;
  logic [7:0] sh;

  initial rxd_o = 1'b1;
  // source channel taken on pending fall
  always @(negedge int_n_i) begin
    #1;
    tag_a = chan_a_i;
    tag_b = chan_b_i;
  end
  always @(posedge clk_i) begin
    if (int_n_i && !int_prev) tail_q.push_back(hi);
    int_prev <= int_n_i;
    lead <= int_n_i ? 0 : lead + 1;
    hi <= (txd_i && !int_n_i) ? hi + 1 : 0;
  end
  ////////////////////////////////////////////////////////////////
  // 8n1 receiver, lsb first, sampled mid bit
  initial begin
    forever begin
      @(negedge txd_i);
      repeat (BIT / 2) @(posedge clk_i);
      lead_q.push_back(lead);
      if (txd_i === 1'b0) begin
        for (int k = 0; k < 8; k++) begin
          repeat (BIT) @(posedge clk_i);
          sh[k] = txd_i;
        end
        repeat (BIT) @(posedge clk_i);
        if (txd_i === 1'b1) got_q.push_back({int_n_i, tag_a, tag_b, sh});
      end
    end
  end
  // telecommand frame: start, 8 data, stop
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      rxd_o = f[i];
      repeat (BIT - 1) @(negedge clk_i);
    end
    @(negedge clk_i);
    rxd_o = 1'b1;
  endtask
endmodule // vsp_host

// [tb/tb_top.sv]
`timescale 1ns/100ps

module tb_top;
  localparam int G = 10;
  localparam int BIT = 86;
  logic clk_i, rst_n_i, rxd, msg_last, msg_chan_b, msg_valid, msg_ready;
  logic txd, int_n, chan_a, chan_b, cmd_valid, cmd_err, saw_full;
  logic [7:0] msg_data, cmd_data, cmd_exp;
  logic [10:0] exp_q[$];
  int n_errors, num_checks, seed, k, n;

  vsp_port #(.GUARD_US(1)) i_vsp_port (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .msg_data_i(msg_data), .msg_last_i(msg_last), .msg_chan_b_i(msg_chan_b),
    .msg_valid_i(msg_valid), .msg_ready_o(msg_ready), .rxd_i(rxd), .txd_o(txd),
    .int_n_o(int_n), .chan_a_o(chan_a), .chan_b_o(chan_b), .cmd_data_o(cmd_data),
    .cmd_valid_o(cmd_valid), .cmd_err_o(cmd_err));
  vsp_host #(.BIT(BIT)) i_vsp_host (.clk_i(clk_i), .txd_i(txd), .int_n_i(int_n),
    .chan_a_i(chan_a), .chan_b_i(chan_b), .rxd_o(rxd));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  function logic idle;
    return txd === 1'b1 && int_n === 1'b1 && chan_a === 1'b0 && chan_b === 1'b0
      && msg_ready === 1'b1;
  endfunction
  // offer one byte, hold it while refused
  task put(input logic [7:0] b, input logic last, input logic chb);
    msg_data = b;
    msg_last = last;
    msg_chan_b = chb;
    msg_valid = 1'b1;
    exp_q.push_back({1'b0, !chb, chb, b});
    k = 0;
    while (msg_ready !== 1'b1 && k < 20000) begin
      saw_full = 1'b1;
      @(negedge clk_i);
      k++;
    end
    if (k >= 20000) begin
      chk(1'b0, "ready timeout");
      close_out;
    end
    @(negedge clk_i);
  endtask
  task drain;
    k = 0;
    while ((exp_q.size() != i_vsp_host.got_q.size() || int_n !== 1'b1) && k < 60000) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= 60000) begin
      chk(1'b0, "message timeout");
      close_out;
    end
    @(negedge clk_i);
    while (exp_q.size() > 0) chk(exp_q.pop_front() === i_vsp_host.got_q.pop_front(), "byte");
    chk(i_vsp_host.lead_q[0] >= G + BIT / 2, "lead guard");
    chk(i_vsp_host.tail_q[$] >= BIT + G, "tail guard");
    i_vsp_host.lead_q.delete();
    chk(idle(), "not idle after message");
  endtask
  task message(input int len, input logic chb);
    for (int j = 0; j < len; j++) put(8'($random(seed)), j == len - 1, chb);
    msg_valid = 1'b0;
    drain;
  endtask
  task cmd(input logic [7:0] b, input logic stop);
    fork
      i_vsp_host.send(b, stop);
      begin
        k = 0;
        while (cmd_valid !== 1'b1 && cmd_err !== 1'b1 && k < 2000) begin
          @(negedge clk_i);
          k++;
        end
        if (k >= 2000) begin
          chk(1'b0, "telecommand timeout");
          close_out;
        end
        if (stop) cmd_exp = b;
        chk(cmd_valid === stop && cmd_err === !stop && cmd_data === cmd_exp, "telecommand");
      end
    join
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 6;
    n_errors = 0;
    num_checks = 0;
    rst_n_i = 1'b0;
    msg_data = 8'h00;
    msg_last = 1'b0;
    msg_chan_b = 1'b0;
    msg_valid = 1'b0;
    saw_full = 1'b0;
    cmd_exp = 8'h00;
    repeat (4) @(negedge clk_i);
    chk(idle() && cmd_valid === 1'b0 && cmd_err === 1'b0, "reset values");
    rst_n_i = 1'b1;
    @(negedge clk_i);
    chk(idle(), "idle after reset");
    message(3, 1'b0);
    message(1, 1'b1);
    message(24, 1'b1);
    chk(saw_full === 1'b1, "buffer never refused");
    for (n = 0; n < 5; n++) cmd(8'($random(seed)), n != 2);
    put(8'h5a, 1'b1, 1'b0);
    msg_valid = 1'b0;
    repeat (300) @(negedge clk_i);
    rst_n_i = 1'b0;
    #1;
    chk(idle(), "async reset mid message");
    repeat (1000) @(negedge clk_i);
    rst_n_i = 1'b1;
    exp_q.delete();
    i_vsp_host.got_q.delete();
    i_vsp_host.lead_q.delete();
    message(2, 1'b0);
    close_out;
  end
endmodule // tb_top
